// *** dv/prog_mem_model.sv ***
// program memory model supplying instruction words and table data
`timescale 1ns/10ps
module prog_mem_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] prog_addr,
  output wire logic [15:0] instr_word,
  input  wire logic [15:0] tbl_addr,
  output wire logic [15:0] tbl_rd_data,
  input  wire logic [15:0] tbl_wr_data,
  input  wire logic        tbl_wr_en
);
  logic [15:0] mem [0:65535];
  int          wr_cnt = 0;

  // unused bits zero
  // blank words read as zero, so unloaded space runs as no-operation
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 16'h0000;
    end
  end

  assign instr_word  = mem[prog_addr];
  assign tbl_rd_data = mem[tbl_addr];

  always @(posedge clk_sys) begin
    if (tbl_wr_en === 1'b1) begin
      mem[tbl_addr] <= tbl_wr_data;
      wr_cnt        <= wr_cnt + 1;
    end
  end
endmodule : prog_mem_model

// *** dv/tb_top.sv ***
// self-checking bench for the decode core and its phase sequencer
`timescale 1ns/10ps
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [7:0]  hw_flag_set = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  wire  [15:0] prog_addr, instr_word, tbl_addr, tbl_rd_data, tbl_wr_data;
  wire         tbl_wr_en, global_irq_disable, awready, wready, bvalid, arready, rvalid;
  wire  [3:0]  cycle_phases;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  logic [31:0] v, pc_a;
  logic [1:0]  r;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  // word three carries a set don't-care bit
  logic [15:0] prog_lo [18] = '{16'h2907, 16'h2b0e, 16'hab20, 16'ha30a, 16'ha021, 16'h0122,
    16'h0e21, 16'h0f22, 16'h8722, 16'h8822, 16'h3922, 16'h6a22, 16'h150d, 16'ha40a,
    16'hae0a, 16'h2903, 16'h1503, 16'h2902};
  // set with s clear fills the accumulator ahead of the flag add
  logic [15:0] prog_hi [5] = '{16'h2903, 16'h4224, 16'h2a25, 16'h0e07, 16'h2904};

  operand_decode_and_q_phase_control dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .prog_addr(prog_addr), .instr_word(instr_word),
    .tbl_addr(tbl_addr), .tbl_rd_data(tbl_rd_data), .tbl_wr_data(tbl_wr_data),
    .tbl_wr_en(tbl_wr_en), .hw_flag_set(hw_flag_set),
    .global_irq_disable(global_irq_disable), .cycle_phases(cycle_phases),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
  );

  prog_mem_model mem_i (
    .clk_sys(clk_sys), .prog_addr(prog_addr), .instr_word(instr_word),
    .tbl_addr(tbl_addr), .tbl_rd_data(tbl_rd_data), .tbl_wr_data(tbl_wr_data),
    .tbl_wr_en(tbl_wr_en)
  );

  always #5 clk_sys = ~clk_sys;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("comparisons=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic load_prog;
    for (int i = 0; i < 18; i++) begin
      mem_i.mem[i] = prog_lo[i];
    end
    for (int i = 0; i < 5; i++) begin
      mem_i.mem[16'h0100 + i] = prog_hi[i];
    end
    mem_i.mem[16'hff00] = 16'h5aa5;
  endtask : load_prog

  task automatic t_reset;
    repeat (16) @(posedge clk_sys);
    check({28'h0, cycle_phases}, 32'h1);
    check({31'h0, global_irq_disable}, 32'h1);
    check({16'h0, prog_addr}, 32'h0);
    check({16'h0, tbl_addr}, 32'h0);
    rst_n <= 1'b1;
  endtask : t_reset

  task automatic t_phases;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (cycle_phases !== 4'h1 && n < 4);
    for (int i = 1; i < 13; i++) begin
      @(posedge clk_sys);
      #1;
      check({28'h0, cycle_phases}, 32'h1 << (i % 4));
    end
  endtask : t_phases

  // hardware flag set mid-run must survive to the final add
  task automatic t_flag_pulse;
    @(posedge clk_sys);
    hw_flag_set <= 8'h81;
    @(posedge clk_sys);
    hw_flag_set <= 8'h00;
  endtask : t_flag_pulse

  task automatic t_halt;
    axi_wr(8'h00, 32'h0, 4'hf);
    check({30'h0, r}, 32'h0);
    axi_rd(8'h00);
    check(v, 32'h0);
    repeat (8) @(posedge clk_sys);
    axi_rd(8'h08);
    pc_a = v;
    repeat (8) @(posedge clk_sys);
    axi_rd(8'h08);
    check(v, pc_a);
  endtask : t_halt

  task automatic t_bus;
    axi_wr(8'h00, 32'h1, 4'h0);
    axi_rd(8'h00);
    check(v, 32'h0);
    axi_rd(8'h10);
    check({v[31:2], r}, 32'h2);
    axi_wr(8'h14, 32'h1, 4'hf);
    check({30'h0, r}, 32'h2);
    axi_wr(8'h04, 32'hffff_ffff, 4'hf);
    check({30'h0, r}, 32'h0);
  endtask : t_bus

  task automatic t_results;
    axi_rd(8'h04);
    check(v, 32'h0010_0480);
    axi_rd(8'h08);
    check(v & 32'h00ff_ff00, 32'h0001_0100);
    axi_rd(8'h0c);
    check(v, 32'hff02_dada);
    check({16'h0, mem_i.mem[16'hff02]}, 32'h0000_dada);
    check(32'(mem_i.wr_cnt), 32'h1);
  endtask : t_results

  // cuts a hang short long after the whole sequence should have ended
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    #1;
    load_prog();
    t_reset();
    t_phases();
    t_flag_pulse();
    repeat (300) @(posedge clk_sys);
    t_halt();
    t_bus();
    t_results();
    complete_run();
  end
endmodule : tb_top

// *** rtl/opdec_map.svh ***
// address map, field layout and reset values of the decode core
`ifndef OPDEC_MAP_SVH
`define OPDEC_MAP_SVH
`define F_FIELD 7:0
`define P_FIELD 12:8
`define B_FIELD 10:8
`define DS_BIT 8
`define T_BIT 9
`define I_BIT 8
`define A_CNT_LO 8'h02
`define A_CNT_HOLD 8'h03
`define A_ALU 8'h04
`define A_CPU 8'h06
`define A_HWFLG 8'h07
`define A_ACC 8'h0a
`define A_TPL 8'h0d
`define A_TPH 8'h0e
`define FLG_C 0
`define FLG_HC 1
`define FLG_Z 2
`define FLG_SW 3
`define GID_BIT 4
`define ALU_RST 8'h00
`define CPU_RST 8'h10
`define MASK_ARITH 4'hf
`define MASK_Z 4'h4
`define MASK_NONE 4'h0
`define REG_CTRL 8'h00
`define REG_CORE 8'h04
`define REG_PC 8'h08
`define REG_TBL 8'h0c
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define NOP_WORD 16'h0000
`endif

// *** rtl/opdec_pkg.sv ***
// types shared by the decode core and its phase sequencer
package opdec_pkg;
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } phase_t;
  typedef enum logic [3:0] {
    OP_NOP, OP_MOVWF, OP_ADD, OP_INC, OP_COM, OP_CLR, OP_SET, OP_MOVPF,
    OP_MOVFP, OP_BCF, OP_BSF, OP_BTG, OP_TLRD, OP_TLWT, OP_TBRD, OP_TBWT
  } op_t;
endpackage : opdec_pkg

// *** rtl/operand_decode_and_q_phase_control.sv ***
// instruction field decoder and four-phase execution core
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`include "opdec_map.svh"
module operand_decode_and_q_phase_control
  import opdec_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  output wire logic [15:0] prog_addr,
  input  wire logic [15:0] instr_word,
  output wire logic [15:0] tbl_addr,
  input  wire logic [15:0] tbl_rd_data,
  output wire logic [15:0] tbl_wr_data,
  output wire logic        tbl_wr_en,
  input  wire logic [7:0]  hw_flag_set,
  output wire logic        global_irq_disable,
  output wire logic [3:0]  cycle_phases,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output wire logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output wire logic        bvalid,
  input  wire logic        bready,
  output wire logic [1:0]  bresp,
  input  wire logic        arvalid,
  output wire logic        arready,
  input  wire logic [7:0]  araddr,
  output wire logic        rvalid,
  input  wire logic        rready,
  output wire logic [31:0] rdata,
  output wire logic [1:0]  rresp
);
  phase_t      phase;
  logic [15:0] ir_r;
  logic        cyc2_r;
  logic [7:0]  acc_r;
  logic [7:0]  alu_r;
  logic [7:0]  cnt_lo_r;
  logic [7:0]  cnt_hi_r;
  logic [7:0]  hold_hi_r;
  logic [7:0]  cpu_r;
  logic [15:0] tptr_r;
  logic [15:0] tlat_r;
  logic [7:0]  mem_r [0:255];
  logic [7:0]  opnd_r;
  logic [7:0]  result_r;
  logic [3:0]  flg_r;
  logic [7:0]  hwpend_r;
  logic        run_r;
  logic        twr_en_r;
  logic [15:0] twr_data_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        wstrb0_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  function automatic op_t decode_op(input logic [15:0] w);
    op_t o;
    o = OP_NOP;
    casez (w[15:8])
      8'b0000_0001: o = OP_MOVWF;
      8'b0000_111?: o = OP_ADD;
      8'b0001_010?: o = OP_INC;
      8'b0001_001?: o = OP_COM;
      8'b0010_100?: o = OP_CLR;
      8'b0010_101?: o = OP_SET;
      8'b010?_????: o = OP_MOVPF;
      8'b011?_????: o = OP_MOVFP;
      8'b1000_1???: o = OP_BCF;
      8'b1000_0???: o = OP_BSF;
      8'b0011_1???: o = OP_BTG;
      8'b1010_00??: o = OP_TLRD;
      8'b1010_01??: o = OP_TLWT;
      8'b1010_10??: o = OP_TBRD;
      8'b1010_11??: o = OP_TBWT;
      default:      o = OP_NOP;
    endcase
    return o;
  endfunction : decode_op

  // {ov, dc, c, sum}
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    logic       ov;
    s  = {1'b0, a} + {1'b0, b};
    h  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    ov = (a[7] == b[7]) && (s[7] != a[7]);
    return {ov, h[4], s[8], s[7:0]};
  endfunction : add8

  function automatic logic is_special(input logic [7:0] a);
    return (a == `A_CNT_LO) || (a == `A_CNT_HOLD) || (a == `A_ALU) || (a == `A_CPU) ||
           (a == `A_ACC) || (a == `A_TPL) || (a == `A_TPH);
  endfunction : is_special

  phase_sequencer u_seq (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .phase   (phase)
  );

  wire q1 = (phase == PH_Q1);
  wire q2 = (phase == PH_Q2);
  wire q3 = (phase == PH_Q3);
  wire q4 = (phase == PH_Q4);

  // decode of the held word; second table cycle runs as a nop
  wire op_t  op      = cyc2_r ? OP_NOP : decode_op(ir_r);
  wire       dbit    = ir_r[`DS_BIT];
  wire       tbit    = ir_r[`T_BIT];
  wire       ibit    = ir_r[`I_BIT];
  wire       tbl_op  = (op == OP_TBRD) || (op == OP_TBWT);
  wire       byte_op = (op == OP_ADD) || (op == OP_INC) || (op == OP_COM);
  wire       alt_op  = (op == OP_CLR) || (op == OP_SET);
  wire [7:0] f_addr  = ir_r[`F_FIELD];
  wire [7:0] p_addr  = {3'h0, ir_r[`P_FIELD]};
  wire [7:0] src_a   = (op == OP_MOVPF) ? p_addr : f_addr;
  wire [7:0] dst_a   = (op == OP_MOVFP) ? p_addr : f_addr;

  wire file_wr = byte_op ? dbit :
                 (op != OP_NOP) && (op != OP_TLWT) && (op != OP_TBWT);
  wire acc_wr  = (byte_op || alt_op) ? !dbit : 1'b0;
  // plain reads only
  // a read-modify-write must not refresh the latch, or the write reloads the old high byte
  wire src_rd  = byte_op || (op == OP_MOVPF) || (op == OP_MOVFP) || (op == OP_BCF) ||
                 (op == OP_BSF) || (op == OP_BTG) || (op == OP_TLWT) || (op == OP_TBWT);
  wire lo_read = src_rd && (src_a == `A_CNT_LO) && !(file_wr && (dst_a == `A_CNT_LO));

  wire [3:0] fmask = ((op == OP_ADD) || (op == OP_INC)) ? `MASK_ARITH :
                     ((op == OP_COM) || (op == OP_MOVPF) || (op == OP_CLR)) ?
                     `MASK_Z : `MASK_NONE;
  wire [7:0] fmask8 = {4'h0, fmask};

  wire [7:0] src_val = (src_a == `A_ACC)    ? acc_r    :
                       (src_a == `A_ALU)    ? alu_r    :
                       (src_a == `A_CNT_LO)   ? cnt_lo_r  :
                       (src_a == `A_CNT_HOLD) ? hold_hi_r :
                       (src_a == `A_CPU)    ? cpu_r    :
                       (src_a == `A_TPL)    ? tptr_r[7:0] :
                       (src_a == `A_TPH)    ? tptr_r[15:8] : mem_r[src_a];

  wire [7:0]  bmask = 8'h01 << ir_r[`B_FIELD];
  wire [10:0] sum_a = add8(acc_r, opnd_r);
  wire [10:0] sum_i = add8(opnd_r, 8'h01);
  wire [10:0] sum   = (op == OP_INC) ? sum_i : sum_a;
  wire [7:0]  tbyte = tbit ? tlat_r[15:8] : tlat_r[7:0];

  // whole byte modified then written back
  wire [7:0] res_val = ((op == OP_ADD) || (op == OP_INC)) ? sum[7:0] :
                       (op == OP_COM)   ? ~opnd_r :
                       (op == OP_MOVWF) ? acc_r :
                       (op == OP_CLR)   ? 8'h00 :
                       (op == OP_SET)   ? 8'hff :
                       (op == OP_BCF)   ? (opnd_r & ~bmask) :
                       (op == OP_BSF)   ? (opnd_r | bmask) :
                       (op == OP_BTG)   ? (opnd_r ^ bmask) :
                       ((op == OP_TLRD) || (op == OP_TBRD)) ? tbyte : opnd_r;
  wire [3:0] flg_val = {sum[10], (res_val == 8'h00), sum[9], sum[8]};

  wire [7:0] alu_wr = ((file_wr && (dst_a == `A_ALU)) ? result_r : alu_r) & ~fmask8 |
                      {4'h0, flg_r} & fmask8;
  wire wr_now = q4 && file_wr;

  // phase one decodes or forces a nop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ir_r <= `NOP_WORD;
    end else if (q1 && !cyc2_r) begin
      ir_r <= run_r ? instr_word : `NOP_WORD;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cyc2_r <= 1'b0;
    end else if (q4) begin
      cyc2_r <= tbl_op;
    end
  end

  // read in two, process in three
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      opnd_r   <= 8'h00;
      result_r <= 8'h00;
      flg_r    <= 4'h0;
    end else if (q2) begin
      opnd_r <= src_val;
    end else if (q3) begin
      result_r <= res_val;
      flg_r    <= flg_val;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      acc_r <= 8'h00;
    end else if (q4 && (acc_wr || (file_wr && (dst_a == `A_ACC)))) begin
      acc_r <= result_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      alu_r <= `ALU_RST;
    end else if (q4) begin
      alu_r <= alu_wr;
    end
  end

  // low byte write pulls high byte from latch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_lo_r <= 8'h00;
      cnt_hi_r <= 8'h00;
    end else if (wr_now && (dst_a == `A_CNT_LO)) begin
      cnt_lo_r <= result_r;
      cnt_hi_r <= hold_hi_r;
    end else if (q1 && !cyc2_r && run_r) begin
      {cnt_hi_r, cnt_lo_r} <= {cnt_hi_r, cnt_lo_r} + 16'h0001;
    end
  end

  // low byte read snapshots high byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hold_hi_r <= 8'h00;
    end else if (wr_now && (dst_a == `A_CNT_HOLD)) begin
      hold_hi_r <= result_r;
    end else if (q2 && lo_read) begin
      hold_hi_r <= cnt_hi_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cpu_r <= `CPU_RST;
    end else if (wr_now && (dst_a == `A_CPU)) begin
      cpu_r <= result_r;
    end
  end

  // bump at end of second cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tptr_r <= 16'h0000;
    end else if (wr_now && (dst_a == `A_TPL)) begin
      tptr_r[7:0] <= result_r;
    end else if (wr_now && (dst_a == `A_TPH)) begin
      tptr_r[15:8] <= result_r;
    end else if (q4 && cyc2_r && ibit) begin
      tptr_r <= tptr_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tlat_r <= 16'h0000;
    end else if (q4 && cyc2_r && (decode_op(ir_r) == OP_TBRD)) begin
      tlat_r <= tbl_rd_data;
    end else if (q4 && ((op == OP_TLWT) || (op == OP_TBWT))) begin
      if (tbit) begin
        tlat_r[15:8] <= opnd_r;
      end else begin
        tlat_r[7:0] <= opnd_r;
      end
    end
  end

  // program memory write fires once after the idle cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      twr_en_r   <= 1'b0;
      twr_data_r <= 16'h0000;
    end else begin
      twr_en_r <= q4 && cyc2_r && (decode_op(ir_r) == OP_TBWT);
      if (q4 && cyc2_r) begin
        twr_data_r <= tlat_r;
      end
    end
  end

  // hardware flags held until phase one, set beats that cycle's clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hwpend_r <= 8'h00;
    end else begin
      hwpend_r <= (q1 ? 8'h00 : hwpend_r) | hw_flag_set;
    end
  end

  // flag merge only in phase one, ahead of any operand read
  always_ff @(posedge clk_sys) begin
    if (wr_now && !is_special(dst_a)) begin
      mem_r[dst_a] <= result_r;
    end else if (q1) begin
      mem_r[`A_HWFLG] <= mem_r[`A_HWFLG] | hwpend_r | hw_flag_set;
    end
  end

  // register bus: address and data latched apart, answered together
  wire aw_take = awvalid && awready;
  wire w_take  = wvalid && wready;
  wire do_wr   = aw_hold_r && w_hold_r && !bvalid_r;
  wire wr_ok   = (awaddr_r == `REG_CTRL) || (awaddr_r == `REG_CORE) ||
                 (awaddr_r == `REG_PC) || (awaddr_r == `REG_TBL);
  wire rd_ok   = (araddr == `REG_CTRL) || (araddr == `REG_CORE) ||
                 (araddr == `REG_PC) || (araddr == `REG_TBL);
  wire [31:0] rd_mux = (araddr == `REG_CTRL) ? {31'h0, run_r} :
                       (araddr == `REG_CORE) ? {8'h00, cpu_r, alu_r, acc_r} :
                       (araddr == `REG_PC)   ? {8'h00, hold_hi_r, cnt_hi_r, cnt_lo_r} :
                       (araddr == `REG_TBL)  ? {tptr_r, tlat_r} : 32'h0;

  assign awready = !aw_hold_r;
  assign wready  = !w_hold_r;
  assign arready = !rvalid_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0;
      wstrb0_r  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= awaddr;
      end else if (do_wr) begin
        aw_hold_r <= 1'b0;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb0_r <= wstrb[0];
      end else if (do_wr) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // only the run bit is writable; status words ignore writes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      run_r    <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end else begin
      if (do_wr && wstrb0_r && (awaddr_r == `REG_CTRL)) begin
        run_r <= wdata_r[0];
      end
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign bvalid             = bvalid_r;
  assign bresp              = bresp_r;
  assign rvalid             = rvalid_r;
  assign rdata              = rdata_r;
  assign rresp              = rresp_r;
  assign prog_addr          = {cnt_hi_r, cnt_lo_r};
  assign tbl_addr           = tptr_r;
  assign tbl_wr_data        = twr_data_r;
  assign tbl_wr_en          = twr_en_r;
  assign cycle_phases       = phase;
  assign global_irq_disable = cpu_r[`GID_BIT];

  sequence s_rotate;
    q1 ##1 q2 ##1 q3 ##1 q4 ##1 q1;
  endsequence

  chk_phase_rotation: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q1 |-> s_rotate) else $error("phase rotation broken");

  chk_reset_phase: assert property (@(posedge clk_sys)
    !rst_n |=> q1) else $error("phase not q1 after reset");

  chk_acc_dest: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q4 && byte_op && !dbit |=> acc_r == $past(result_r))
    else $error("accumulator not written");

  chk_alt_dest: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q4 && alt_op && !dbit |=> acc_r == $past(result_r))
    else $error("accumulator not written by clear or set");

  chk_cnt_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q2 && lo_read |=> hold_hi_r == $past(cnt_hi_r))
    else $error("holding latch not loaded");

  chk_cnt_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_now && (dst_a == `A_CNT_LO) |=>
    {cnt_hi_r, cnt_lo_r} == {$past(hold_hi_r), $past(result_r)})
    else $error("counter load wrong");

  chk_clr_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_now && (op == OP_CLR) && (dst_a == `A_ALU) |=> alu_r == 8'h04)
    else $error("zero flag not forced");

  sequence s_tbl_pair;
    q4 ##1 cyc2_r [*4];
  endsequence

  chk_table_cycles: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q4 && tbl_op |-> s_tbl_pair ##1 !cyc2_r) else $error("table op not two cycles");

  chk_tptr_bump: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q4 && cyc2_r && ibit |=> tptr_r == $past(tptr_r) + 16'h0001)
    else $error("table pointer not advanced");

  chk_hw_flag_q1: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q1 && (hwpend_r != 8'h00) |=> (mem_r[`A_HWFLG] & $past(hwpend_r)) == $past(hwpend_r))
    else $error("hardware flag lost");

  chk_bit_rmw: assert property (@(posedge clk_sys) disable iff (!rst_n)
    q3 && (op == OP_BSF) |=> ((result_r ^ $past(opnd_r)) & ~$past(bmask)) == 8'h00)
    else $error("bit op touched other bits");
endmodule : operand_decode_and_q_phase_control

// *** rtl/phase_sequencer.sv ***
// four-phase instruction cycle sequencer, one phase per clock
`timescale 1ns/10ps
module phase_sequencer
  import opdec_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output phase_t    phase
);
  phase_t phase_r;
  phase_t phase_nxt;

  always_comb begin
    case (phase_r)
      PH_Q1:   phase_nxt = PH_Q2;
      PH_Q2:   phase_nxt = PH_Q3;
      PH_Q3:   phase_nxt = PH_Q4;
      PH_Q4:   phase_nxt = PH_Q1;
      default: phase_nxt = PH_Q1;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_r <= PH_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign phase = phase_r;
endmodule : phase_sequencer
